//--- core/bsr_params.svh
// Constants for the BISYNC receive mode control block
`ifndef BSR_PARAMS_SVH
`define BSR_PARAMS_SVH
`define BSR_REG_CTRL 4'h0
`define BSR_REG_STAT 4'h1
`define BSR_REG_BCC 4'h2
`define BSR_REG_CNT 4'h3
`define BSR_REG_TXD 4'h4
`define BSR_REG_CODE 2'h2
`define BSR_CTL_RXEN 0
`define BSR_CTL_DDCMP 1
`define BSR_CTL_TXEND 2
`define BSR_CTL_REINIT 3
`define BSR_CTL_TXTRN 4
`define BSR_ST_ERR 8
`define BSR_ST_EOB 9
`define BSR_ST_TRN 10
`define BSR_ST_BCCZ 11
`define BSR_ST_TXBSY 12
`define BSR_CNT_MARK 15
`define BSR_CODE_W0 32'h0102102D
`define BSR_CODE_W1 32'h6B703D37
`define BSR_CODE_W2 32'h03261F7C
`define BSR_CODE_W3 32'h00000032
`define BSR_NUM_CODES 13
`define BSR_CRC_POLY 16'hA001
`define BSR_BCC_LEN 2'h2
`endif

//--- core/bsr_pkg.sv
// Types for the BISYNC receive mode control block
package bsr_pkg;
    typedef enum logic [2:0] {
        bsr_wait, bsr_ttrn, bsr_ntxt, bsr_ttxt, bsr_tctl, bsr_tint
    } bsr_mode_t;
    typedef enum logic [1:0] {bsr_tx_ctl, bsr_tx_data, bsr_tx_end} bsr_txm_t;
    typedef enum logic [3:0] {
        bsr_enq, bsr_dle, bsr_stx, bsr_soh, bsr_eot, bsr_nak, bsr_ack,
        bsr_wack, bsr_rvi, bsr_itb, bsr_etb, bsr_etx, bsr_syn, bsr_other
    } bsr_class_t;
    typedef struct packed {
        logic store;
        logic accum;
        logic event_hit;
        logic err;
        logic eob;
        logic trn;
        logic bcc_next;
        logic clr;
        bsr_mode_t next;
    } bsr_act_t;
endpackage : bsr_pkg

//--- core/bsr_top.sv
// BISYNC/DDCMP receive mode control with transmit DLE stuffing
`timescale 1ns/1ps
`default_nettype none
`include "bsr_params.svh"
module bsr_top
    import bsr_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [3:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rd_data,
    input wire logic [7:0] rx_char,
    input wire logic rx_valid,
    output logic [7:0] buf_data,
    output logic buf_write,
    output logic host_event,
    output logic [7:0] tx_char,
    output logic tx_valid,
    input wire logic tx_take
);

////////////////////////////////////////////////////////////////////////
// Reset release
logic [1:0] rst_sync_reg;
logic rst_n;
always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        rst_sync_reg <= 2'h0;
    end else begin
        rst_sync_reg <= {rst_sync_reg[0], 1'h1};
    end
end
assign rst_n = rst_sync_reg[1];

////////////////////////////////////////////////////////////////////////
// Functions
logic [31:0] code_reg [0:3];

// Classify a character against host-loaded codes
function automatic bsr_class_t classify(input logic [7:0] c);
    bsr_class_t r;
    r = bsr_other;
    for (int i = `BSR_NUM_CODES - 1; i >= 0; i--) begin
        if (code_reg[i / 4][(i % 4) * 8 +: 8] == c) begin
            r = bsr_class_t'(i[3:0]);
        end
    end
    return r;
endfunction : classify

// Block check update, one byte, low bit first
function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    logic fb;
    c = crc;
    for (int i = 0; i < 8; i++) begin
        fb = c[0] ^ d[i];
        c = {1'h0, c[15:1]};
        if (fb) begin
            c = c ^ `BSR_CRC_POLY;
        end
    end
    return c;
endfunction : crc_byte

// Per-mode action for a character class
function automatic bsr_act_t decide(input bsr_mode_t m, input bsr_class_t k);
    bsr_act_t a;
    a = '0;
    a.next = m;
    unique case (m)
        bsr_wait: begin
            unique case (k)
                bsr_enq, bsr_eot, bsr_nak: begin
                    a.store = 1'h1;
                    a.event_hit = 1'h1;
                end
                bsr_dle: a.next = bsr_ttrn;
                bsr_stx, bsr_soh: begin
                    a.store = 1'h1;
                    a.clr = 1'h1;
                    a.next = bsr_ntxt;
                end
                default: begin
                    a.store = 1'h1;
                    a.event_hit = 1'h1;
                end
            endcase
        end
        bsr_ttrn: begin
            a.event_hit = 1'h1;
            a.next = bsr_wait;
            unique case (k)
                bsr_stx: begin
                    a.trn = 1'h1;
                    a.clr = 1'h1;
                    a.next = bsr_ttxt;
                end
                bsr_ack, bsr_wack, bsr_rvi: a.next = bsr_wait;
                bsr_enq: a.err = 1'h1;
                default: a.store = 1'h1;
            endcase
        end
        bsr_ntxt: begin
            unique case (k)
                bsr_itb: begin
                    a.store = 1'h1;
                    a.accum = 1'h1;
                    a.bcc_next = 1'h1;
                    a.event_hit = 1'h1;
                end
                bsr_etb, bsr_etx: begin
                    a.store = 1'h1;
                    a.accum = 1'h1;
                    a.bcc_next = 1'h1;
                    a.eob = 1'h1;
                    a.event_hit = 1'h1;
                    a.next = bsr_wait;
                end
                bsr_enq: begin
                    a.err = 1'h1;
                    a.event_hit = 1'h1;
                    a.next = bsr_wait;
                end
                bsr_syn: a.store = 1'h0;
                default: begin
                    a.store = 1'h1;
                    a.accum = 1'h1;
                end
            endcase
        end
        bsr_ttxt: begin
            if (k == bsr_dle) begin
                a.next = bsr_tctl;
            end else begin
                a.store = 1'h1;
                a.accum = 1'h1;
            end
        end
        bsr_tctl: begin
            a.next = bsr_ttxt;
            unique case (k)
                bsr_itb: begin
                    a.store = 1'h1;
                    a.accum = 1'h1;
                    a.bcc_next = 1'h1;
                    a.next = bsr_tint;
                end
                bsr_etb, bsr_etx: begin
                    a.store = 1'h1;
                    a.accum = 1'h1;
                    a.bcc_next = 1'h1;
                    a.eob = 1'h1;
                    a.event_hit = 1'h1;
                    a.next = bsr_wait;
                end
                bsr_dle: begin
                    a.store = 1'h1;
                    a.accum = 1'h1;
                    a.next = bsr_ntxt;
                end
                bsr_stx: a.accum = 1'h1;
                bsr_enq: begin
                    a.store = 1'h1;
                    a.err = 1'h1;
                    a.event_hit = 1'h1;
                    a.next = bsr_wait;
                end
                bsr_syn: a.store = 1'h0;
                default: begin
                    a.store = 1'h1;
                    a.accum = 1'h1;
                end
            endcase
        end
        bsr_tint: begin
            unique case (k)
                bsr_syn: a.store = 1'h0;
                bsr_dle: begin
                    a.accum = 1'h1;
                    a.next = bsr_tctl;
                end
                default: begin
                    a.store = 1'h1;
                    a.err = 1'h1;
                    a.event_hit = 1'h1;
                    a.next = bsr_wait;
                end
            endcase
        end
    endcase
    return a;
endfunction : decide

////////////////////////////////////////////////////////////////////////
// Registers and state
logic rxen_reg, ddcmp_reg, txtrn_reg;
bsr_mode_t mode_reg;
bsr_txm_t txm_reg;
logic [15:0] bcc_reg;
logic [15:0] cnt_reg;
logic [1:0] bcc_left_reg;
logic err_reg, eob_reg, trn_reg, bccz_reg;
logic [7:0] txq_reg;
logic txq_full_reg, stuffed_reg;

logic take, ctl_wr, stat_wr;
bsr_act_t act;
logic [15:0] bcc_next_val;
logic cnt_zero;
assign take = rx_valid && rxen_reg;
assign ctl_wr = wr_en && (addr == `BSR_REG_CTRL);
assign stat_wr = wr_en && (addr == `BSR_REG_STAT);

// Action for the incoming character
always_comb begin
    act = '0;
    act.next = mode_reg;
    if (bcc_left_reg != 2'h0 || ddcmp_reg) begin
        act.store = 1'h1;
        act.accum = 1'h1;
    end else begin
        act = decide(mode_reg, classify(rx_char));
    end
    bcc_next_val = crc_byte(bcc_reg, rx_char);
end

// Byte count runs out on this stored character
assign cnt_zero = take && act.store && (cnt_reg[14:0] == 15'h1);

////////////////////////////////////////////////////////////////////////
// Receive mode
always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        mode_reg <= bsr_wait;
    end else if (ctl_wr && wr_data[`BSR_CTL_REINIT]) begin
        mode_reg <= bsr_wait;
    end else if (take) begin
        mode_reg <= act.next;
    end
end

// Block check accumulation
always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        bcc_reg <= 16'h0;
    end else if (wr_en && addr == `BSR_REG_CNT) begin
        bcc_reg <= 16'h0;
    end else if (take && act.clr) begin
        bcc_reg <= 16'h0;
    end else if (take && act.accum) begin
        bcc_reg <= bcc_next_val;
    end
end

// Byte count and check-byte tracking
always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        cnt_reg <= 16'h0;
        bcc_left_reg <= 2'h0;
    end else begin
        if (wr_en && addr == `BSR_REG_CNT) begin
            cnt_reg <= wr_data[15:0];
        end else if (take && act.store && cnt_reg[14:0] != 15'h0) begin
            cnt_reg <= {cnt_reg[15], cnt_reg[14:0] - 15'h1};
        end
        if (take && bcc_left_reg != 2'h0) begin
            bcc_left_reg <= bcc_left_reg - 2'h1;
        end else if (take && act.bcc_next) begin
            bcc_left_reg <= `BSR_BCC_LEN;
        end else if (cnt_zero && ddcmp_reg && !cnt_reg[`BSR_CNT_MARK]) begin
            bcc_left_reg <= `BSR_BCC_LEN;
        end
    end
end

// Sticky flags, set wins over clear; check-zero flag reloaded at each check end
always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        err_reg <= 1'h0;
        eob_reg <= 1'h0;
        trn_reg <= 1'h0;
        bccz_reg <= 1'h0;
    end else begin
        err_reg <= (take && act.err) || (err_reg && !(stat_wr && wr_data[`BSR_ST_ERR]));
        eob_reg <= (take && act.eob) || (eob_reg && !(stat_wr && wr_data[`BSR_ST_EOB]));
        trn_reg <= (take && act.trn) || (trn_reg && !(stat_wr && wr_data[`BSR_ST_TRN]));
        if (take && bcc_left_reg == 2'h1) begin
            bccz_reg <= (bcc_next_val == 16'h0);
        end else if (stat_wr && wr_data[`BSR_ST_BCCZ]) begin
            bccz_reg <= 1'h0;
        end
    end
end

// Buffer write and host event outputs
always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        buf_data <= 8'h0;
        buf_write <= 1'h0;
        host_event <= 1'h0;
    end else begin
        buf_write <= take && act.store;
        if (take && act.store) begin
            buf_data <= rx_char;
        end
        host_event <= take && (act.event_hit || cnt_zero || bcc_left_reg == 2'h1);
    end
end

////////////////////////////////////////////////////////////////////////
// Transmit stuffing
bsr_class_t tx_cls;
logic need_stuff, slot_free;
assign slot_free = !tx_valid || tx_take;

// Class of the queued character and whether it gets a DLE in front
always_comb begin
    tx_cls = classify(txq_reg); // Follows code table rewrites too
    need_stuff = 1'h0;
    if (txtrn_reg) begin
        unique case (txm_reg)
            bsr_tx_ctl: need_stuff = (tx_cls == bsr_ack) || (tx_cls == bsr_wack) ||
                                     (tx_cls == bsr_rvi) || (tx_cls == bsr_stx);
            bsr_tx_data: need_stuff = (tx_cls == bsr_dle);
            bsr_tx_end: need_stuff = (tx_cls == bsr_itb) || (tx_cls == bsr_etb) ||
                                     (tx_cls == bsr_etx);
        endcase
    end
end

// Queue slot, line output and send mode
always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        txq_reg <= 8'h0;
        txq_full_reg <= 1'h0;
        stuffed_reg <= 1'h0;
        tx_char <= 8'h0;
        tx_valid <= 1'h0;
        txm_reg <= bsr_tx_ctl;
    end else begin
        if (tx_take) begin
            tx_valid <= 1'h0;
        end
        if (ctl_wr && wr_data[`BSR_CTL_TXEND]) begin
            txm_reg <= bsr_tx_end;
        end
        if (wr_en && addr == `BSR_REG_TXD && !txq_full_reg) begin
            txq_reg <= wr_data[7:0];
            txq_full_reg <= 1'h1;
        end else if (txq_full_reg && slot_free) begin
            tx_valid <= 1'h1;
            if (need_stuff && !stuffed_reg) begin
                tx_char <= code_reg[0][15:8];
                stuffed_reg <= 1'h1;
            end else begin
                tx_char <= txq_reg;
                txq_full_reg <= 1'h0;
                stuffed_reg <= 1'h0;
                if (txtrn_reg && tx_cls == bsr_stx && txm_reg != bsr_tx_data) begin
                    txm_reg <= bsr_tx_data;
                end else if (txm_reg == bsr_tx_end &&
                             (tx_cls == bsr_etb || tx_cls == bsr_etx)) begin
                    txm_reg <= bsr_tx_ctl;
                end
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Register port
always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        rxen_reg <= 1'h0;
        ddcmp_reg <= 1'h0;
        txtrn_reg <= 1'h0;
        code_reg[0] <= `BSR_CODE_W0;
        code_reg[1] <= `BSR_CODE_W1;
        code_reg[2] <= `BSR_CODE_W2;
        code_reg[3] <= `BSR_CODE_W3;
    end else if (wr_en) begin
        if (addr == `BSR_REG_CTRL) begin
            rxen_reg <= wr_data[`BSR_CTL_RXEN];
            ddcmp_reg <= wr_data[`BSR_CTL_DDCMP];
            txtrn_reg <= wr_data[`BSR_CTL_TXTRN];
        end
        if (addr[3:2] == `BSR_REG_CODE) begin
            code_reg[addr[1:0]] <= wr_data;
        end
    end
end

// Read data, valid in the cycle after the strobe
always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        rd_data <= 32'h0;
    end else if (rd_en) begin
        rd_data <= 32'h0;
        if (addr == `BSR_REG_CTRL) begin
            rd_data[`BSR_CTL_RXEN] <= rxen_reg;
            rd_data[`BSR_CTL_DDCMP] <= ddcmp_reg;
            rd_data[`BSR_CTL_TXTRN] <= txtrn_reg;
        end else if (addr == `BSR_REG_STAT) begin
            rd_data <= {19'h0, txq_full_reg, bccz_reg, trn_reg, eob_reg, err_reg,
                        2'h0, txm_reg, 1'h0, mode_reg};
        end else if (addr == `BSR_REG_BCC) begin
            rd_data[15:0] <= bcc_reg;
        end else if (addr == `BSR_REG_CNT) begin
            rd_data[15:0] <= cnt_reg;
        end else if (addr[3:2] == `BSR_REG_CODE) begin
            rd_data <= code_reg[addr[1:0]];
        end
    end
end

endmodule : bsr_top
`default_nettype wire

//--- tb/bsr_remote.sv
// Remote station model: sends characters and takes sent ones
`timescale 1ns/1ps
`default_nettype none
module bsr_remote (
    input wire logic mclk,
    output logic [7:0] rx_char,
    output logic rx_valid,
    input wire logic [7:0] tx_char,
    input wire logic tx_valid,
    output logic tx_take,
    input wire logic slow
);
    logic [7:0] got[$];
    // Idle line levels
    initial begin
        rx_char = 8'hA5;
        rx_valid = 1'b0;
        tx_take = 1'b0;
    end
    // One character per frame, inverse on the released line
    task send(input logic [7:0] c);
        @(posedge mclk);
        rx_char <= c;
        rx_valid <= 1'b1;
        @(posedge mclk);
        rx_valid <= 1'b0;
        rx_char <= ~c;
    endtask : send
    // Take sent characters promptly or every other cycle
    always @(posedge mclk) begin
        if (tx_valid && tx_take) got.push_back(tx_char);
        tx_take <= slow ? ~tx_take : 1'b1;
    end
endmodule : bsr_remote
`default_nettype wire

//--- tb/bsr_chk.sv
// Port checker for the receive mode control block
`timescale 1ns/1ps
`default_nettype none
module bsr_chk (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [3:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [31:0] rd_data,
    input wire logic [7:0] rx_char,
    input wire logic rx_valid,
    input wire logic [7:0] buf_data,
    input wire logic buf_write,
    input wire logic host_event,
    input wire logic [7:0] tx_char,
    input wire logic tx_valid,
    input wire logic tx_take
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // Outputs quiet while reset is held
    a_reset_idle: assert property (disable iff (1'b0) !nrst |-> !buf_write && !host_event && !tx_valid)
        else $error("output active in reset");
    // Stores and events follow a taken character
    a_buf_src: assert property (buf_write |-> $past(rx_valid))
        else $error("store without character");
    a_buf_data: assert property (buf_write |-> buf_data == $past(rx_char))
        else $error("stored character differs");
    a_event_src: assert property (host_event |-> $past(rx_valid))
        else $error("event without character");
    // Send side holds its character until taken
    a_tx_hold: assert property (tx_valid && !tx_take |=> tx_valid && $stable(tx_char))
        else $error("send character dropped");
    a_tx_start: assert property ($rose(tx_valid) |-> $past(wr_en && addr == 4'h4, 2) || $past(tx_take))
        else $error("send without request");
    // Read port
    a_rd_hold: assert property (!$past(rd_en) |-> $stable(rd_data))
        else $error("read data moved");
    a_rd_unmap: assert property (rd_en && addr == 4'h5 |=> rd_data == 32'h0)
        else $error("unmapped read not zero");
    c_event: cover property (host_event);
    c_store: cover property (buf_write ##1 buf_write);
    c_take: cover property (tx_valid && tx_take ##1 tx_valid);
endmodule : bsr_chk
bind bsr_top bsr_chk u_chk(.mclk(mclk), .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .rx_char(rx_char), .rx_valid(rx_valid), .buf_data(buf_data),
    .buf_write(buf_write), .host_event(host_event), .tx_char(tx_char), .tx_valid(tx_valid), .tx_take(tx_take));
`default_nettype wire

//--- tb/tb_bsr_top.sv
// Testbench for the receive mode control block
`timescale 1ns/1ps
`default_nettype none
`include "bsr_params.svh"
module tb_bsr_top;
    logic mclk = 1'b0;
    logic nrst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wr_data = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic slow = 1'b0;
    logic [31:0] rd_data, st_v;
    logic [7:0] rx_char, buf_data, tx_char;
    logic rx_valid, buf_write, host_event, tx_valid, tx_take;
    logic [15:0] crc;
    int n_mismatch = 0;
    int n_checks = 0;
    int n_buf = 0;
    int n_ev = 0;
    // Clock and parts
    always #4 mclk = ~mclk;
    bsr_top u_dut(.mclk(mclk), .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .rx_char(rx_char), .rx_valid(rx_valid), .buf_data(buf_data), .buf_write(buf_write),
        .host_event(host_event), .tx_char(tx_char), .tx_valid(tx_valid), .tx_take(tx_take));
    bsr_remote u_rem(.mclk(mclk), .rx_char(rx_char), .rx_valid(rx_valid), .tx_char(tx_char),
        .tx_valid(tx_valid), .tx_take(tx_take), .slow(slow));
    // Count stores and host events
    always @(posedge mclk) begin
        if (buf_write === 1'b1) n_buf++;
        if (host_event === 1'b1) n_ev++;
    end
    task end_of_test;
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test
    task chk(input logic [31:0] g, input logic [31:0] e, input string m);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk
    // Register bus cycles
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask : wr
    task rdchk(input logic [3:0] a, input logic [31:0] e);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 st_v = rd_data;
        if (a != 4'h1) chk(st_v, e, "read");
    endtask : rdchk
    function automatic logic [15:0] crc_add(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) r = r[0] ? (r >> 1) ^ `BSR_CRC_POLY : r >> 1;
        return r;
    endfunction : crc_add
    // Send one character, judge store, event and mode (-1 skips)
    task step(input logic [7:0] c, input int s, input int e, input int m);
        int b0, e0;
        b0 = n_buf;
        e0 = n_ev;
        u_rem.send(c);
        rdchk(4'h1, 32'h0);
        if (s >= 0) chk(n_buf - b0, s, "store");
        if (e >= 0) chk(n_ev - e0, e, "event");
        if (m >= 0) chk(st_v[2:0], m, "mode");
    endtask : step
    task bcc2(input logic [15:0] v);
        step(v[7:0], 1, 0, -1);
        step(v[15:8], 1, 1, -1);
    endtask : bcc2
    task enter4;
        step(8'h10, 0, 0, 1);
        step(8'h02, 0, 1, 3);
        step(8'h10, 0, 0, 4);
    endtask : enter4
    task t_regs;
        rdchk(4'h0, 32'h0);
        rdchk(4'h2, 32'h0);
        rdchk(4'h8, `BSR_CODE_W0);
        rdchk(4'hA, `BSR_CODE_W2);
        wr(4'h5, 32'hFFFFFFFF);
        rdchk(4'h5, 32'h0);
        step(8'h2D, 0, 0, 0);
    endtask : t_regs
    task t_wait;
        wr(4'h0, 32'h1);
        step(8'h2D, 1, 1, 0);
        step(8'h37, 1, 1, 0);
        step(8'h3D, 1, 1, 0);
        step(8'h01, 1, 0, 2);
        step(8'h2D, 0, 1, 0);
        chk(st_v[8], 1, "err");
        wr(4'h1, 32'h00000F00);
    endtask : t_wait
    task t_text;
        step(8'h02, 1, 0, 2);
        step(8'h41, 1, 0, 2);
        step(8'h32, 0, 0, 2);
        step(8'h1F, 1, -1, 2);
        crc = crc_add(crc_add(16'h0, 8'h41), 8'h1F);
        rdchk(4'h2, {16'h0, crc});
        bcc2(crc);
        chk(st_v[11], 1, "bcc zero");
        wr(4'hB, 32'h00000055);
        step(8'h55, 0, 0, 2);
        step(8'h32, 1, 0, 2);
        wr(4'hB, `BSR_CODE_W3);
        step(8'h26, 1, -1, 0);
        crc = crc_add(crc_add(16'h0, 8'h32), 8'h26);
        rdchk(4'h2, {16'h0, crc});
        bcc2(crc);
        chk(st_v[11:9], 3'b101, "eob");
    endtask : t_text
    task t_trn;
        logic [7:0] acks[3] = '{8'h70, 8'h6B, 8'h7C};
        wr(4'h1, 32'h00000F00);
        step(8'h10, 0, 0, 1);
        step(8'h02, 0, 1, 3);
        chk(st_v[10], 1, "trn");
        step(8'h41, 1, 0, 3);
        step(8'h10, 0, 0, 4);
        step(8'h10, 1, 0, 2);
        wr(4'h0, 32'h9);
        enter4;
        step(8'h32, 0, 0, 3);
        step(8'h10, 0, 0, 4);
        step(8'h42, 1, 0, 3);
        step(8'h10, 0, 0, 4);
        step(8'h1F, 1, -1, -1);
        bcc2(16'h1234);
        step(8'h32, 0, 0, 5);
        step(8'h10, 0, 0, 4);
        step(8'h03, 1, -1, 0);
        bcc2(16'h0000);
        chk(st_v[9], 1, "eob");
        enter4;
        step(8'h1F, 1, -1, -1);
        bcc2(16'h0000);
        step(8'h41, 1, 1, 0);
        chk(st_v[8], 1, "err");
        wr(4'h1, 32'h00000F00);
        enter4;
        step(8'h2D, 1, 1, 0);
        chk(st_v[8], 1, "err");
        wr(4'h1, 32'h00000F00);
        foreach (acks[i]) begin
            step(8'h10, 0, 0, 1);
            step(acks[i], 0, 1, 0);
        end
        step(8'h10, 0, 0, 1);
        step(8'h2D, -1, 1, 0);
        chk(st_v[8], 1, "err");
        step(8'h10, 0, 0, 1);
        step(8'h41, 1, 1, 0);
    endtask : t_trn
    task t_ddcmp;
        wr(4'h0, 32'h3);
        wr(4'h3, 32'h2);
        step(8'h41, 1, 0, -1);
        step(8'h42, 1, 1, -1);
        crc = crc_add(crc_add(16'h0, 8'h41), 8'h42);
        rdchk(4'h2, {16'h0, crc});
        bcc2(crc);
        chk(st_v[11], 1, "bcc zero");
        rdchk(4'h2, 32'h0);
        wr(4'h3, 32'h2);
        step(8'h41, 1, 0, -1);
        step(8'h42, 1, 1, -1);
        bcc2(~crc);
        chk(st_v[11], 0, "bcc bad");
    endtask : t_ddcmp
    // Send one character, expect an optional stuffed DLE first
    task txs(input logic [7:0] c, input int n);
        wr(4'h4, {24'h0, c});
        for (int i = 0; i < 30 && u_rem.got.size() < n; i++) @(posedge mclk);
        repeat (3) @(posedge mclk);
        chk(u_rem.got.size(), n, "sent count");
        if (n == 2) chk(u_rem.got.pop_front(), 8'h10, "stuff");
        chk(u_rem.got.pop_front(), c, "sent char");
    endtask : txs
    task t_tx;
        logic [7:0] ctl[3] = '{8'h70, 8'h6B, 8'h7C};
        wr(4'h0, 32'h11);
        slow <= 1'b1;
        txs(8'h02, 2);
        slow <= 1'b0;
        txs(8'h10, 2);
        txs(8'h41, 1);
        wr(4'h0, 32'h15);
        txs(8'h03, 2);
        foreach (ctl[i]) txs(ctl[i], 2);
        txs(8'h41, 1);
        rdchk(4'h1, 32'h0);
        chk(st_v[12], 0, "busy");
    endtask : t_tx
    // Main sequence
    initial begin
        nrst <= 1'b0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
        t_regs;
        t_wait;
        t_text;
        t_trn;
        t_ddcmp;
        t_tx;
        end_of_test;
    end
    // Watchdog
    initial begin
        #200000;
        n_mismatch++;
        end_of_test;
    end
endmodule : tb_bsr_top
`default_nettype wire
